// file: shared/pscl_pkg.sv
/*
  pscl_pkg: constants for the strap capture and indicator block.
  Assumes a single 10 MHz clock; register indices are word indices.
*/
package pscl_pkg;
  // ****************************
  // clock and timing
  // ****************************
  localparam int CLK_HZ      = 10_000_000;
  localparam int BLINK_MS    = 50;                         // blink half period
  localparam int BLINK_CYC   = (CLK_HZ / 1000) * BLINK_MS;
  // ****************************
  // register bus
  // ****************************
  localparam int         ADDR_W    = 7;
  localparam logic [4:0] IDX_CTRL  = 5'h00;
  localparam logic [4:0] IDX_ADV   = 5'h04;
  localparam logic [4:0] IDX_WAKE  = 5'h16;
  localparam logic [4:0] IDX_STRAP = 5'h1A;
  localparam logic [4:0] IDX_LED   = 5'h1F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLV  = 2'h2;
  // ****************************
  // field positions
  // ****************************
  localparam int CTRL_SPEED = 13;
  localparam int ADV_100FD  = 8;
  localparam int ADV_100HD  = 7;
  localparam int WAKE_EN    = 15;
  localparam int BCAST_OFF  = 9;
  localparam int LED_LSB    = 4;
  // ****************************
  // codes and reset values
  // ****************************
  localparam logic [2:0] MODE_RMII = 3'h1;
  localparam logic [2:0] MODE_B2B  = 3'h5;
  localparam logic [1:0] LED_SPEED = 2'h0;
  localparam logic [1:0] LED_ACT   = 2'h1;
  localparam logic [1:0] LED_RST   = 2'h0;
  localparam logic [1:0] ADDR_HI   = 2'h0;
  // ****************************
  // shared pin positions
  // ****************************
  localparam int NPIN      = 9;
  localparam int PIN_ADDR  = 0;
  localparam int PIN_MODE  = 3;
  localparam int PIN_WAKE  = 6;
  localparam int PIN_BCAST = 7;
  localparam int PIN_LED   = 8;
  typedef enum logic [1:0] {
    CAP_WAIT = 2'b01,
    CAP_DONE = 2'b10
  } pscl_cap_e;
endpackage

// file: rtl/pscl_sync.sv
/*
  pscl_sync: two flip-flop synchroniser, one per bit.
  Assumes inputs are asynchronous pins; no reset so pin levels flow during reset.
*/
`timescale 1ns/100ps
module pscl_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         clk_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  generate
    if (W < 1) begin : g_chk
      $error("pscl_sync width must be at least 1");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      // first flop feeds only the second
      always_ff @(posedge clk_i) begin
        meta_reg <= d_i[i];
        sync_reg <= meta_reg;
      end
      assign q_o[i] = sync_reg;
    end
  endgenerate
endmodule

// file: rtl/pscl_led.sv
/*
  pscl_led: speed/activity indicator driver with blink timer.
  Assumes mode, speed and activity come from logic on the same clock.
*/
`timescale 1ns/100ps
module pscl_led #(
  parameter int BLINK_CYC = pscl_pkg::BLINK_CYC
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // control
  input  wire logic [1:0] mode_i,
  input  wire logic       speed100_i,
  input  wire logic       activity_i,
  // pin level
  output logic            led_o
);
  localparam int CW = $clog2(BLINK_CYC + 1);
  generate
    if (BLINK_CYC < 1) begin : g_chk
      $error("pscl_led blink count must be at least 1");
    end
  endgenerate

  logic [CW-1:0] cnt_reg, cnt_next;
  logic          tog_reg, tog_next;
  logic          led_reg, led_next;

  // blink timer and pin level select
  always_comb begin
    cnt_next = cnt_reg;
    tog_next = tog_reg;
    if (!activity_i) begin
      cnt_next = '0;
      tog_next = 1'b1;
    end else if (cnt_reg == CW'(BLINK_CYC - 1)) begin
      cnt_next = '0;
      tog_next = ~tog_reg;
    end else begin
      cnt_next = cnt_reg + CW'(1);
    end
    unique case (mode_i)
      pscl_pkg::LED_SPEED: led_next = ~speed100_i;
      pscl_pkg::LED_ACT:   led_next = activity_i ? tog_reg : 1'b1;
      default:             led_next = 1'b1;
    endcase
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_reg <= '0;
      tog_reg <= 1'b1;
      led_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      tog_reg <= tog_next;
      led_reg <= led_next;
    end
  end
  assign led_o = led_reg;
endmodule

// file: rtl/pscl_top.sv
/*
  pscl_top: strap capture at reset release, shared pin direction control,
  RMII dibit transfer and indicator driver, with an AXI4-Lite register slave.
  Assumes rstn_i is the chip reset, synchronous to clk_i; shared pins and
  RMII transmit pins are asynchronous and are synchronised here.
*/
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
// Operation
// - Indicator mode 00 drives the pin high at 10 Mbps and low at 100 Mbps.
// - Indicator mode 01 holds the pin high when idle and toggles it on activity.
// - The reset input is active low and holds every register except the synchronisers in reset.
// - Strap pins are inputs during reset and become outputs afterwards.
// - Receive presents two data bits per clock while data valid is high.
// - Transmit takes two data bits per clock while transmit enable is high.
// - Straps are sampled once at reset release and then held.
// - Three address straps give the low station address bits 2 to 0.
// - Address 0 is broadcast unless the strap or control bit 9 disables it.
// - Station address bits 4 and 3 are zero.
// - Interface mode code 001 selects RMII and 101 selects back-to-back.
// - The wake enable strap is latched into control bit 15 at release.
// - The indicator pin level is latched as the speed select bit 13.
// - A high speed strap selects 100 Mbps and is copied to the advertisement.
module pscl_top #(
  parameter int BLINK_CYC = pscl_pkg::BLINK_CYC
) (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  // shared strap pins
  input  wire logic [pscl_pkg::NPIN-1:0]   pin_i,
  output logic      [pscl_pkg::NPIN-1:0]   pin_o,
  output logic      [pscl_pkg::NPIN-1:0]   pin_oe_o,
  // rmii transmit pins from the mac
  input  wire logic                        txen_i,
  input  wire logic [1:0]                  txd_i,
  // core side receive
  input  wire logic                        rx_valid_i,
  input  wire logic [1:0]                  rx_dibit_i,
  input  wire logic                        rx_err_i,
  input  wire logic                        wake_evt_i,
  // core side transmit
  output logic                             tx_valid_o,
  output logic [1:0]                       tx_dibit_o,
  // configuration out
  output logic [4:0]                       station_addr_o,
  output logic                             bcast_en_o,
  output logic                             rmii_mode_o,
  output logic                             b2b_mode_o,
  output logic                             speed100_o,
  // axi4-lite write
  input  wire logic [pscl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // axi4-lite read
  input  wire logic [pscl_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);
  // ****************************
  // synchronisers
  // ****************************
  logic [pscl_pkg::NPIN-1:0] pin_s;
  logic [2:0]                tx_s;

  pscl_sync #(.W(pscl_pkg::NPIN)) u_pin_sync (
    .clk_i (clk_i),
    .d_i   (pin_i),
    .q_o   (pin_s)
  );
  pscl_sync #(.W(3)) u_tx_sync (
    .clk_i (clk_i),
    .d_i   ({txen_i, txd_i}),
    .q_o   (tx_s)
  );

  // ****************************
  // strap capture
  // ****************************
  pscl_pkg::pscl_cap_e cap_reg, cap_next;
  logic [2:0] addr_reg,  addr_next;
  logic [2:0] mode_reg,  mode_next;
  logic       bstr_reg,  bstr_next;
  logic       speed_reg, speed_next;
  logic       adv_reg,   adv_next;
  logic       wake_reg,  wake_next;
  logic       boff_reg,  boff_next;
  logic [1:0] led_reg,   led_next;
  logic       cap_done;
  logic       wr_fire;
  logic [4:0] wr_idx;
  logic [31:0] wmask;

  assign cap_done = (cap_reg == pscl_pkg::CAP_DONE);

  // capture straps once, then apply software writes
  always_comb begin
    cap_next   = cap_reg;
    addr_next  = addr_reg;
    mode_next  = mode_reg;
    bstr_next  = bstr_reg;
    adv_next   = adv_reg;
    speed_next = speed_reg;
    wake_next  = wake_reg;
    boff_next  = boff_reg;
    led_next   = led_reg;
    unique case (cap_reg)
      pscl_pkg::CAP_WAIT: begin
        cap_next   = pscl_pkg::CAP_DONE;
        addr_next  = pin_s[pscl_pkg::PIN_ADDR +: 3];
        mode_next  = pin_s[pscl_pkg::PIN_MODE +: 3];
        bstr_next  = pin_s[pscl_pkg::PIN_BCAST];
        wake_next  = pin_s[pscl_pkg::PIN_WAKE];
        speed_next = pin_s[pscl_pkg::PIN_LED];
        adv_next   = pin_s[pscl_pkg::PIN_LED];
      end
      pscl_pkg::CAP_DONE: begin
        if (wr_fire && wr_idx == pscl_pkg::IDX_CTRL && wmask[pscl_pkg::CTRL_SPEED]) begin
          speed_next = s_axi_wdata[pscl_pkg::CTRL_SPEED];
        end
        if (wr_fire && wr_idx == pscl_pkg::IDX_WAKE) begin
          if (wmask[pscl_pkg::WAKE_EN]) begin
            wake_next = s_axi_wdata[pscl_pkg::WAKE_EN];
          end
          if (wmask[pscl_pkg::BCAST_OFF]) begin
            boff_next = s_axi_wdata[pscl_pkg::BCAST_OFF];
          end
        end
        if (wr_fire && wr_idx == pscl_pkg::IDX_LED && wmask[pscl_pkg::LED_LSB]) begin
          led_next = s_axi_wdata[pscl_pkg::LED_LSB +: 2];
        end
      end
    endcase
  end

  // capture registers; reset holds everything
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cap_reg   <= pscl_pkg::CAP_WAIT;
      addr_reg  <= 3'h0;
      mode_reg  <= 3'h0;
      bstr_reg  <= 1'b0;
      adv_reg   <= 1'b0;
      speed_reg <= 1'b0;
      wake_reg  <= 1'b0;
      boff_reg  <= 1'b0;
      led_reg   <= pscl_pkg::LED_RST;
    end else begin
      cap_reg   <= cap_next;
      addr_reg  <= addr_next;
      mode_reg  <= mode_next;
      bstr_reg  <= bstr_next;
      adv_reg   <= adv_next;
      speed_reg <= speed_next;
      wake_reg  <= wake_next;
      boff_reg  <= boff_next;
      led_reg   <= led_next;
    end
  end

  // decoded configuration
  assign station_addr_o = {pscl_pkg::ADDR_HI, addr_reg};
  assign bcast_en_o     = ~(bstr_reg | boff_reg);
  assign rmii_mode_o    = cap_done && (mode_reg == pscl_pkg::MODE_RMII);
  assign b2b_mode_o     = cap_done && (mode_reg == pscl_pkg::MODE_B2B);
  assign speed100_o     = speed_reg;

  // ****************************
  // rmii data path and pins
  // ****************************
  logic [1:0] rxd_reg,  rxd_next;
  logic       crs_reg,  crs_next;
  logic       rxer_reg, rxer_next;
  logic       wko_reg,  wko_next;
  logic       txv_reg,  txv_next;
  logic [1:0] txd_reg,  txd_next;
  logic       led_pin;

  pscl_led #(.BLINK_CYC(BLINK_CYC)) u_led (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .mode_i     (led_reg),
    .speed100_i (speed_reg),
    .activity_i (crs_reg | txv_reg),
    .led_o      (led_pin)
  );

  // one dibit per clock in each direction
  always_comb begin
    crs_next  = rx_valid_i;
    rxd_next  = rx_valid_i ? rx_dibit_i : 2'h0;
    rxer_next = rx_err_i;
    wko_next  = wake_evt_i & wake_reg;
    txv_next  = tx_s[2];
    txd_next  = tx_s[2] ? tx_s[1:0] : 2'h0;
  end

  // data path registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rxd_reg  <= 2'h0;
      crs_reg  <= 1'b0;
      rxer_reg <= 1'b0;
      wko_reg  <= 1'b0;
      txv_reg  <= 1'b0;
      txd_reg  <= 2'h0;
    end else begin
      rxd_reg  <= rxd_next;
      crs_reg  <= crs_next;
      rxer_reg <= rxer_next;
      wko_reg  <= wko_next;
      txv_reg  <= txv_next;
      txd_reg  <= txd_next;
    end
  end

  assign tx_valid_o = txv_reg;
  assign tx_dibit_o = txd_reg;

  // output functions of the shared pins
  assign pin_o    = {led_pin, rxer_reg, wko_reg, 3'h0, crs_reg, rxd_reg};
  assign pin_oe_o = {pscl_pkg::NPIN{cap_done}};

  // ****************************
  // axi4-lite slave
  // ****************************
  logic                        awg_reg, awg_next;
  logic                        wg_reg,  wg_next;
  logic [pscl_pkg::ADDR_W-1:0] awa_reg, awa_next;
  logic [31:0]                 wd_reg,  wd_next;
  logic [3:0]                  ws_reg,  ws_next;
  logic                        bv_reg,  bv_next;
  logic [1:0]                  br_reg,  br_next;
  logic                        rv_reg,  rv_next;
  logic [31:0]                 rd_reg,  rd_next;
  logic [1:0]                  rr_reg,  rr_next;
  logic [4:0]                  rd_idx;
  logic                        wr_ok;

  assign s_axi_awready = ~awg_reg & ~bv_reg;
  assign s_axi_wready  = ~wg_reg & ~bv_reg;
  assign s_axi_arready = ~rv_reg;
  assign wr_fire = awg_reg & wg_reg & ~bv_reg;
  assign wr_idx  = awa_reg[pscl_pkg::ADDR_W-1:2];
  assign rd_idx  = s_axi_araddr[pscl_pkg::ADDR_W-1:2];
  assign wmask   = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};
  assign wr_ok   = (wr_idx == pscl_pkg::IDX_CTRL) || (wr_idx == pscl_pkg::IDX_WAKE) ||
                   (wr_idx == pscl_pkg::IDX_LED);

  // write and read channel state
  always_comb begin
    awg_next = awg_reg;
    wg_next  = wg_reg;
    awa_next = awa_reg;
    wd_next  = wd_reg;
    ws_next  = ws_reg;
    bv_next  = bv_reg;
    br_next  = br_reg;
    rv_next  = rv_reg;
    rd_next  = rd_reg;
    rr_next  = rr_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      awg_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wg_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      awg_next = 1'b0;
      wg_next  = 1'b0;
      bv_next  = 1'b1;
      br_next  = wr_ok ? pscl_pkg::RESP_OKAY : pscl_pkg::RESP_SLV;
    end else if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_next = 1'b1;
      rd_next = 32'h0000_0000;
      rr_next = pscl_pkg::RESP_OKAY;
      unique case (rd_idx)
        pscl_pkg::IDX_CTRL:  rd_next[pscl_pkg::CTRL_SPEED] = speed_reg;
        pscl_pkg::IDX_ADV: begin
          rd_next[pscl_pkg::ADV_100FD] = adv_reg;
          rd_next[pscl_pkg::ADV_100HD] = adv_reg;
        end
        pscl_pkg::IDX_WAKE: begin
          rd_next[pscl_pkg::WAKE_EN]   = wake_reg;
          rd_next[pscl_pkg::BCAST_OFF] = boff_reg;
        end
        pscl_pkg::IDX_LED:   rd_next[pscl_pkg::LED_LSB +: 2] = led_reg;
        pscl_pkg::IDX_STRAP: rd_next[11:0] = {cap_done, b2b_mode_o, rmii_mode_o,
                                              bstr_reg, mode_reg, station_addr_o};
        default:             rr_next = pscl_pkg::RESP_SLV;
      endcase
    end else if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
  end

  // bus registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      awg_reg <= 1'b0;
      wg_reg  <= 1'b0;
      awa_reg <= '0;
      wd_reg  <= 32'h0000_0000;
      ws_reg  <= 4'h0;
      bv_reg  <= 1'b0;
      br_reg  <= 2'h0;
      rv_reg  <= 1'b0;
      rd_reg  <= 32'h0000_0000;
      rr_reg  <= 2'h0;
    end else begin
      awg_reg <= awg_next;
      wg_reg  <= wg_next;
      awa_reg <= awa_next;
      wd_reg  <= wd_next;
      ws_reg  <= ws_next;
      bv_reg  <= bv_next;
      br_reg  <= br_next;
      rv_reg  <= rv_next;
      rd_reg  <= rd_next;
      rr_reg  <= rr_next;
    end
  end

  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp  = br_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata  = rd_reg;
  assign s_axi_rresp  = rr_reg;
endmodule

// file: tb/pscl_top_props.sv
/*
  pscl_top_props: port-level checker for pscl_top.
  Assumes it is bound into pscl_top and sees that module's ports only.
*/
`timescale 1ns/100ps
module pscl_top_props #(
  parameter int BLINK_CYC = 4
) (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rstn_i,
  // shared pins
  input wire logic [8:0] pin_i,
  input wire logic [8:0] pin_o,
  input wire logic [8:0] pin_oe_o,
  // data paths
  input wire logic       txen_i,
  input wire logic [1:0] txd_i,
  input wire logic       rx_valid_i,
  input wire logic [1:0] rx_dibit_i,
  input wire logic       rx_err_i,
  input wire logic       tx_valid_o,
  input wire logic [1:0] tx_dibit_o,
  // configuration
  input wire logic [4:0] station_addr_o,
  input wire logic       bcast_en_o,
  input wire logic       rmii_mode_o,
  input wire logic       b2b_mode_o,
  input wire logic       speed100_o
);
  // ********************
  // properties
  // ********************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // first clock edge with reset released
  sequence s_release;
    $rose(rstn_i);
  endsequence
  property p_rst_state;
    s_release |-> pin_o[8] && pin_o[2:0] == 3'h0;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("pins not in reset state");
  property p_oe;
    s_release |-> pin_oe_o == 9'h000 ##1 pin_oe_o == 9'h1FF;
  endproperty
  a_oe: assert property (p_oe) else $error("pin enables wrong at release");
  property p_addr;
    s_release |=> station_addr_o == {2'h0, $past(pin_i[2:0])};
  endproperty
  a_addr: assert property (p_addr) else $error("station address not captured");
  property p_cfg;
    s_release |=> bcast_en_o == !$past(pin_i[7]) && speed100_o == $past(pin_i[8]);
  endproperty
  a_cfg: assert property (p_cfg) else $error("broadcast or speed not captured");
  property p_mode;
    s_release |=> rmii_mode_o == ($past(pin_i[5:3]) == 3'h1)
      && b2b_mode_o == ($past(pin_i[5:3]) == 3'h5);
  endproperty
  a_mode: assert property (p_mode) else $error("interface mode decode wrong");
  property p_hold;
    $past(pin_oe_o[0]) |-> $stable(station_addr_o) && $stable({rmii_mode_o, b2b_mode_o});
  endproperty
  a_hold: assert property (p_hold) else $error("captured straps changed");
  property p_rx;
    $past(rstn_i) |-> pin_o[2:0] == $past({rx_valid_i, rx_dibit_i & {2{rx_valid_i}}})
      && pin_o[7] == $past(rx_err_i);
  endproperty
  a_rx: assert property (p_rx) else $error("receive pins not one cycle late");
  property p_tx;
    $past(rstn_i) |-> tx_valid_o == $past(txen_i, 3)
      && tx_dibit_o == ($past(txen_i, 3) ? $past(txd_i, 3) : 2'h0);
  endproperty
  a_tx: assert property (p_tx) else $error("transmit dibit not three cycles late");
endmodule

bind pscl_top pscl_top_props #(.BLINK_CYC(BLINK_CYC)) u_props (
  .clk_i(clk_i), .rstn_i(rstn_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
  .txen_i(txen_i), .txd_i(txd_i), .rx_valid_i(rx_valid_i), .rx_dibit_i(rx_dibit_i),
  .rx_err_i(rx_err_i), .tx_valid_o(tx_valid_o), .tx_dibit_o(tx_dibit_o),
  .station_addr_o(station_addr_o), .bcast_en_o(bcast_en_o), .rmii_mode_o(rmii_mode_o),
  .b2b_mode_o(b2b_mode_o), .speed100_o(speed100_o)
);

// file: tb/pscl_partner.sv
/*
  pscl_partner: board strap pulls and the transmit side of the mac.
  Assumes the bench sets pull levels and frame timing on clk_i.
*/
`timescale 1ns/100ps
module pscl_partner (
  // clock
  input  wire logic       clk_i,
  // pull levels and frame control
  input  wire logic [8:0] strap_i,
  input  wire logic       tx_on_i,
  // shared pins
  input  wire logic [8:0] pin_o,
  input  wire logic [8:0] pin_oe_o,
  output logic      [8:0] pin_i,
  // rmii transmit
  output logic            txen_o,
  output logic      [1:0] txd_o
);
  // a released pin settles to its pull level
  always_comb begin
    for (int b = 0; b < 9; b++) begin
      pin_i[b] = pin_oe_o[b] ? pin_o[b] : strap_i[b];
    end
  end
  // fresh dibit each frame clock, junk between frames
  initial begin
    txen_o = 1'b0;
    txd_o  = 2'h0;
  end
  always @(posedge clk_i) begin
    txen_o <= tx_on_i;
    txd_o  <= tx_on_i ? 2'($urandom) : ~txd_o;
  end
endmodule

// file: tb/tb.sv
/*
  tb: self-checking bench for pscl_top with an axi4-lite master.
  Assumes pscl_partner supplies pin pulls and mac transmit traffic.
*/
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("unexpected at %0t: %h not %h", $time, got, exp); \
  end \
end
module tb;
  // ********************
  // signals
  // ********************
  localparam int BLK = 4;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} pscl_exp_s;
  pscl_exp_s                   sb[$];
  pscl_exp_s                   e;
  int                          fail_count = 0;
  int                          checks_done = 0;
  logic                        clk_i, rstn_i = 1'b0, tx_on = 1'b0;
  logic [8:0]                  strap = 9'h109, pin_i, pin_o, pin_oe_o;
  logic [6:0]                  s_axi_awaddr = 7'h00, s_axi_araddr = 7'h00;
  logic [31:0]                 s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]                  s_axi_bresp, s_axi_rresp, txd_i, tx_dibit_o;
  logic [1:0]                  rx_dibit_i = 2'h0;
  logic                        rx_valid_i = 1'b0, rx_err_i = 1'b0, wake_evt_i = 1'b0;
  logic                        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic                        s_axi_rvalid, txen_i, tx_valid_o, bcast_en_o;
  logic                        rmii_mode_o, b2b_mode_o, speed100_o;
  logic [4:0]                  station_addr_o;
  pscl_top #(.BLINK_CYC(BLK)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .txen_i(txen_i), .txd_i(txd_i), .rx_valid_i(rx_valid_i), .rx_dibit_i(rx_dibit_i),
    .rx_err_i(rx_err_i), .wake_evt_i(wake_evt_i), .tx_valid_o(tx_valid_o),
    .tx_dibit_o(tx_dibit_o), .station_addr_o(station_addr_o), .bcast_en_o(bcast_en_o),
    .rmii_mode_o(rmii_mode_o), .b2b_mode_o(b2b_mode_o), .speed100_o(speed100_o),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  pscl_partner u_mac (
    .clk_i(clk_i), .strap_i(strap), .tx_on_i(tx_on), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pin_i(pin_i), .txen_o(txen_i), .txd_o(txd_i)
  );
  // 100 ns clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // ********************
  // tasks
  // ********************
  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [4:0] idx, input logic [31:0] d, input logic [1:0] r);
    int         n = 0;
    logic [2:0] f;
    sb.push_back('{32'h0, 32'h0, r});
    @(posedge clk_i);
    s_axi_awaddr  <= {idx, 2'h0};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge clk_i);
      f = {s_axi_awready, s_axi_wready, s_axi_bvalid};
      @(posedge clk_i);
      if (f[2]) s_axi_awvalid <= 1'b0;
      if (f[1]) s_axi_wvalid <= 1'b0;
      n++;
    end while (f[0] !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    if (n >= 40) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic axi_rd(input logic [4:0] idx, input logic [31:0] d, input logic [31:0] m,
                        input logic [1:0] r);
    int         n = 0;
    logic [1:0] f;
    sb.push_back('{d, m, r});
    @(posedge clk_i);
    s_axi_araddr  <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge clk_i);
      f = {s_axi_arready, s_axi_rvalid};
      @(posedge clk_i);
      if (f[1]) s_axi_arvalid <= 1'b0;
      n++;
    end while (f[0] !== 1'b1 && n < 40);
    s_axi_rready <= 1'b0;
    if (n >= 40) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic do_reset(input logic [8:0] s);
    @(posedge clk_i);
    strap  <= s;
    rstn_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(negedge clk_i);
    `CHK(pin_oe_o, 9'h000)
    `CHK(pin_o[8], 1'b1)
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    `CHK(pin_oe_o, 9'h1FF)
  endtask
  // responses matched in order against the notes
  always @(negedge clk_i) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      e = sb.pop_front();
      `CHK(s_axi_bresp, e.r)
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      e = sb.pop_front();
      `CHK(s_axi_rdata & e.m, e.d)
      `CHK(s_axi_rresp, e.r)
    end
  end
  // ********************
  // scenarios
  // ********************
  initial begin
    logic [31:0] v;
    int          t;
    logic        lv;
    void'($urandom(32'hABC9));
    // each mode code on random straps, then default pulls
    for (int m = 0; m < 9; m++) begin
      v = $urandom;
      v[5:3] = 3'(m);
      if (m == 8) v[8:0] = 9'h109;
      do_reset(v[8:0]);
      `CHK(station_addr_o, {2'h0, v[2:0]})
      `CHK({b2b_mode_o, rmii_mode_o}, {v[5:3] == 3'h5, v[5:3] == 3'h1})
      `CHK(bcast_en_o, ~v[7])
      `CHK(speed100_o, v[8])
      axi_rd(pscl_pkg::IDX_STRAP, {20'h0, 1'b1, 2'h0, v[7], v[5:3], 2'h0, v[2:0]},
             32'h9FF, pscl_pkg::RESP_OKAY);
      axi_rd(pscl_pkg::IDX_STRAP, {21'h0, v[5:3] == 3'h5, v[5:3] == 3'h1, 9'h0},
             32'h600, pscl_pkg::RESP_OKAY);
      axi_rd(pscl_pkg::IDX_CTRL, {18'h0, v[8], 13'h0}, 32'h2000, pscl_pkg::RESP_OKAY);
      axi_rd(pscl_pkg::IDX_ADV, {23'h0, v[8], v[8], 7'h0}, 32'h180, pscl_pkg::RESP_OKAY);
      axi_rd(pscl_pkg::IDX_WAKE, {16'h0, v[6], 15'h0}, 32'h8200, pscl_pkg::RESP_OKAY);
      axi_rd(pscl_pkg::IDX_LED, 32'h0, 32'h30, pscl_pkg::RESP_OKAY);
    end
    // software turns wake output on and broadcast off
    axi_wr(pscl_pkg::IDX_WAKE, 32'h8200, pscl_pkg::RESP_OKAY);
    repeat (2) @(negedge clk_i);
    `CHK(bcast_en_o, 1'b0)
    // random receive traffic, errors and wake events
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      v = $urandom;
      rx_valid_i <= v[0];
      rx_dibit_i <= v[2:1];
      rx_err_i   <= v[3];
      wake_evt_i <= v[4];
      @(posedge clk_i);
      @(negedge clk_i);
      `CHK(pin_o[2:0], {v[0], v[2:1] & {2{v[0]}}})
      `CHK(pin_o[7:6], {v[3], v[4]})
    end
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    // speed mode at both speeds; reserved modes never written
    axi_wr(pscl_pkg::IDX_LED, 32'h0, pscl_pkg::RESP_OKAY);
    for (int s = 0; s < 2; s++) begin
      axi_wr(pscl_pkg::IDX_CTRL, 32'(s) << pscl_pkg::CTRL_SPEED, pscl_pkg::RESP_OKAY);
      repeat (3) @(negedge clk_i);
      `CHK(speed100_o, 1'(s))
      `CHK(pin_o[8], ~1'(s))
    end
    // activity mode: off when idle, blinking while receiving
    axi_wr(pscl_pkg::IDX_LED, 32'h10, pscl_pkg::RESP_OKAY);
    repeat (3) @(negedge clk_i);
    `CHK(pin_o[8], 1'b1)
    @(posedge clk_i);
    rx_valid_i <= 1'b1;
    t = 0;
    lv = pin_o[8];
    repeat (24) begin
      @(negedge clk_i);
      if (pin_o[8] !== lv) t++;
      lv = pin_o[8];
    end
    `CHK(t >= 24 / BLK - 2, 1'b1)
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    repeat (6) @(negedge clk_i);
    `CHK(pin_o[8], 1'b1)
    // unmapped place answers with an error
    axi_rd(5'h05, 32'h0, 32'h0, pscl_pkg::RESP_SLV);
    axi_wr(5'h05, 32'hFFFFFFFF, pscl_pkg::RESP_SLV);
    // a transmit frame from the mac
    @(posedge clk_i);
    tx_on <= 1'b1;
    repeat (30) @(posedge clk_i);
    tx_on <= 1'b0;
    repeat (6) @(posedge clk_i);
    summarize();
  end
endmodule
